// file: common/tcc_cfg.svh
// Constants of the eight-bit timer compare core
//
// Functional notes
// - Timer held off while power reduce bit set
// - Counter and both compares are eight bits
// - Every request shows as flag, individually masked
// - Clock select zero stops the counter
// - Async select switches to crystal oscillator clock
// - Bottom at zero, max at FF, mode-chosen top
// - Clear, increment or decrement by one per tick
// - Counter readable and writable without timer clock
// - Counter write beats clear and count
// - Three-bit mode field split over two registers
// - Overflow flag set per mode, maskable request
// - Continuous equality compare per channel
// - Compare flag set one timer tick after match
// - Compare request masked; cleared when serviced
// - Writing one clears flag, zero leaves it
// - Output from match, mode and output mode
// - Max and bottom handle extreme cases
// - Each channel drives its own compare pin
// - PWM compare writes buffered, others direct
// - Counter write blocks next tick's matches
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_BOTTOM 8'h00
`define TCC_MAX 8'hFF
`define TCC_CNT_RST 8'h00
`define TCC_CMP_RST 8'h00
`define TCC_FLAG_RST 3'b000

// Cycles the oscillator filter needs after reset before edges count
`define TCC_OSC_SETTLE 3'h6

// Flag and mask bit positions
`define TCC_OVF_BIT 0
`define TCC_CMPA_BIT 1
`define TCC_CMPB_BIT 2

// Waveform mode field codes
`define TCC_WM_NORMAL 3'h0
`define TCC_WM_PC_MAX 3'h1
`define TCC_WM_CTC 3'h2
`define TCC_WM_FAST_MAX 3'h3
`define TCC_WM_PC_CMPA 3'h5
`define TCC_WM_FAST_CMPA 3'h7

// Compare output mode codes
`define TCC_COM_OFF 2'h0
`define TCC_COM_TOGGLE 2'h1
`define TCC_COM_CLEAR 2'h2
`define TCC_COM_SET 2'h3

// Prescaler tap masks per clock select code
`define TCC_PRE_DIV8 10'h007
`define TCC_PRE_DIV32 10'h01F
`define TCC_PRE_DIV64 10'h03F
`define TCC_PRE_DIV128 10'h07F
`define TCC_PRE_DIV256 10'h0FF
`define TCC_PRE_DIV1024 10'h3FF

`endif

// file: common/tcc_pkg.sv
// Types shared by the timer compare core
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_UP = 2'b01,
		TCC_DOWN = 2'b10
	} tcc_dir_e;
	typedef logic [7:0] tcc_byte_t;
endpackage

// file: rtl/tcc_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module tcc_sync (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Asynchronous level in, filtered level out
	input wire logic async_in,
	output logic level
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Only a level seen by both late stages is accepted
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			level <= 1'b0;
		end else if (stage2 == stage3) begin
			level <= stage3;
		end
	end
endmodule

// file: rtl/tcc_chan.sv
// One compare channel: value buffer and waveform output
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_chan
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Compare value write
	input wire logic cpu_wr,
	input wire tcc_byte_t cpu_data,
	input wire logic reload,
	// Timing from the counter
	input wire logic match,
	input wire logic bottom_evt,
	input wire logic force_strobe,
	input wire logic fast_pwm,
	input wire logic pc_pwm,
	input wire logic count_up,
	input wire logic [1:0] out_mode,
	// Results
	output tcc_byte_t cmp_active,
	output tcc_byte_t cmp_buffer,
	output logic pin
);
	logic pwm;
	logic oc_state;

	assign pwm = fast_pwm | pc_pwm;

	// Buffer is what software sees in every mode
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_buffer <= `TCC_CMP_RST;
		end else if (cpu_wr) begin
			cmp_buffer <= cpu_data;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_active <= `TCC_CMP_RST;
		end else if (!pwm && cpu_wr) begin
			cmp_active <= cpu_data;
		end else if (pwm && reload) begin
			cmp_active <= cmp_buffer;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			oc_state <= 1'b0;
		end else if (fast_pwm) begin
			// Bottom wins so a top-valued compare stays one level
			if (bottom_evt && out_mode[1]) begin
				oc_state <= ~out_mode[0];
			end else if (match && out_mode[1]) begin
				oc_state <= out_mode[0];
			end
		end else if (pc_pwm) begin
			if (match && out_mode[1]) begin
				oc_state <= out_mode[0] ^ ~count_up;
			end
		end else if (match || force_strobe) begin
			case (out_mode)
				`TCC_COM_TOGGLE: oc_state <= ~oc_state;
				`TCC_COM_CLEAR: oc_state <= 1'b0;
				`TCC_COM_SET: oc_state <= 1'b1;
				default: oc_state <= oc_state;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pin <= 1'b0;
		end else begin
			pin <= oc_state & (out_mode != `TCC_COM_OFF);
		end
	end
endmodule

// file: rtl/tcc_top.sv
// Eight-bit timer with two compare channels and crystal clock
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_top
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Power and clock configuration
	input wire logic power_reduce_timer,
	input wire logic async_select,
	input wire logic [2:0] clock_select_field,
	// Mode configuration, low bits from control A, high bit from B
	input wire logic waveform_mode_bit0,
	input wire logic waveform_mode_bit1,
	input wire logic waveform_mode_bit2,
	input wire logic [1:0] compare_output_mode_a,
	input wire logic [1:0] compare_output_mode_b,
	// Counter and compare writes
	input wire logic count_wr,
	input wire tcc_byte_t count_wr_data,
	input wire logic compare_wr_a,
	input wire logic compare_wr_b,
	input wire tcc_byte_t compare_wr_data,
	input wire logic force_compare_strobe_a,
	input wire logic force_compare_strobe_b,
	// Flag clear by one-write, service acknowledge, mask
	input wire logic flag_wr,
	input wire logic [2:0] flag_wr_data,
	input wire logic [2:0] irq_ack,
	input wire logic [2:0] timer_mask_reg,
	// Crystal oscillator pins
	input wire logic osc_pin_in,
	output logic osc_pin_out,
	// Status
	output tcc_byte_t count_value,
	output tcc_byte_t compare_value_a,
	output tcc_byte_t compare_value_b,
	output logic [2:0] timer_flag_reg,
	output logic [2:0] irq_req,
	output logic at_bottom,
	output logic at_max,
	// Compare pins
	output logic compare_pin_a,
	output logic compare_pin_b
);
	////////////////////////////////////////////////////////////////////
	// Clock source and prescaler

	logic osc_level;
	logic osc_prev;
	logic src_tick;
	logic [9:0] pre_cnt;
	logic [9:0] pre_mask;
	logic tick;
	logic enabled;
	logic [2:0] osc_settle;
	logic osc_ready;

	tcc_sync u_osc_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.async_in(osc_pin_in),
		.level(osc_level)
	);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			osc_prev <= 1'b0;
		end else begin
			osc_prev <= osc_level;
		end
	end

	// Feedback drive for the crystal, inverted like an amplifier
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			osc_pin_out <= 1'b1;
		end else begin
			osc_pin_out <= ~osc_level;
		end
	end

	// Pin already high at reset must not count as a rising edge
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			osc_settle <= 3'h0;
		end else if (osc_settle != `TCC_OSC_SETTLE) begin
			osc_settle <= osc_settle + 3'h1;
		end
	end

	assign osc_ready = osc_settle == `TCC_OSC_SETTLE;
	assign enabled = ~power_reduce_timer;
	// Oscillator edges only count after the filter agrees
	assign src_tick = async_select ?
		(osc_ready & osc_level & ~osc_prev) : 1'b1;

	always_comb begin
		case (clock_select_field)
			3'h2: pre_mask = `TCC_PRE_DIV8;
			3'h3: pre_mask = `TCC_PRE_DIV32;
			3'h4: pre_mask = `TCC_PRE_DIV64;
			3'h5: pre_mask = `TCC_PRE_DIV128;
			3'h6: pre_mask = `TCC_PRE_DIV256;
			3'h7: pre_mask = `TCC_PRE_DIV1024;
			default: pre_mask = 10'h000;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pre_cnt <= 10'h000;
		end else if (!enabled || clock_select_field == 3'h0) begin
			pre_cnt <= 10'h000;
		end else if (src_tick) begin
			pre_cnt <= pre_cnt + 10'h001;
		end
	end

	assign tick = enabled && clock_select_field != 3'h0 && src_tick &&
		(pre_cnt & pre_mask) == pre_mask;

	////////////////////////////////////////////////////////////////////
	// Mode decode

	logic [2:0] waveform_mode_field;
	logic fast_pwm;
	logic pc_pwm;
	logic ctc;
	logic top_cmpa;
	tcc_byte_t top_val;
	tcc_byte_t cmp_a;
	tcc_byte_t cmp_b;

	assign waveform_mode_field = {waveform_mode_bit2, waveform_mode_bit1,
		waveform_mode_bit0};
	assign fast_pwm = waveform_mode_field == `TCC_WM_FAST_MAX ||
		waveform_mode_field == `TCC_WM_FAST_CMPA;
	assign pc_pwm = waveform_mode_field == `TCC_WM_PC_MAX ||
		waveform_mode_field == `TCC_WM_PC_CMPA;
	assign ctc = waveform_mode_field == `TCC_WM_CTC;
	assign top_cmpa = ctc || waveform_mode_field == `TCC_WM_PC_CMPA ||
		waveform_mode_field == `TCC_WM_FAST_CMPA;
	assign top_val = top_cmpa ? cmp_a : `TCC_MAX;

	////////////////////////////////////////////////////////////////////
	// Counter unit

	tcc_dir_e dir;
	logic at_top;
	logic wrap_evt;
	logic turn_evt;
	logic ovf_evt;
	logic block_match;
	logic match_a;
	logic match_b;

	assign at_top = count_value == top_val;
	// Fast and clear-on-top modes restart at top, phase correct never wraps, others roll at max
	assign wrap_evt = tick && !pc_pwm &&
		((fast_pwm || ctc) ? at_top : count_value == `TCC_MAX);
	assign turn_evt = tick && pc_pwm && dir == TCC_UP && at_top;
	assign ovf_evt = !count_wr && enabled && (wrap_evt || (tick && pc_pwm &&
		dir == TCC_DOWN && count_value == `TCC_BOTTOM));

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			count_value <= `TCC_CNT_RST;
		end else if (count_wr && enabled) begin
			count_value <= count_wr_data;
		end else if (wrap_evt) begin
			count_value <= `TCC_BOTTOM;
		end else if (tick && pc_pwm) begin
			if ((dir == TCC_UP) != at_top && count_value != `TCC_BOTTOM ||
				(dir == TCC_UP && !at_top)) begin
				count_value <= count_value + 8'h01;
			end else if (dir == TCC_DOWN && count_value == `TCC_BOTTOM) begin
				count_value <= count_value + 8'h01;
			end else begin
				count_value <= count_value - 8'h01;
			end
		end else if (tick) begin
			count_value <= count_value + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dir <= TCC_UP;
		end else if (!pc_pwm) begin
			dir <= TCC_UP;
		end else if (tick && !count_wr) begin
			case (dir)
				TCC_UP: if (at_top) dir <= TCC_DOWN;
				TCC_DOWN: if (count_value == `TCC_BOTTOM) dir <= TCC_UP;
				default: dir <= TCC_UP;
			endcase
		end
	end

	// Blocking lasts until the next tick, even while stopped
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			block_match <= 1'b0;
		end else if (count_wr && enabled) begin
			block_match <= 1'b1;
		end else if (tick) begin
			block_match <= 1'b0;
		end
	end

	// Equality is sampled at the tick that leaves the matching value
	assign match_a = tick && !count_wr && !block_match &&
		count_value == cmp_a;
	assign match_b = tick && !count_wr && !block_match &&
		count_value == cmp_b;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			at_bottom <= 1'b1;
			at_max <= 1'b0;
		end else begin
			at_bottom <= count_value == `TCC_BOTTOM;
			at_max <= count_value == `TCC_MAX;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Compare channels

	logic reload;
	logic bottom_evt;

	// Fast PWM reloads at bottom, phase correct at top
	assign reload = fast_pwm ? wrap_evt : turn_evt;
	assign bottom_evt = wrap_evt && !count_wr;

	tcc_chan u_chan_a (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.cpu_wr(compare_wr_a && enabled),
		.cpu_data(compare_wr_data),
		.reload(reload),
		.match(match_a),
		.bottom_evt(bottom_evt),
		.force_strobe(force_compare_strobe_a && enabled),
		.fast_pwm(fast_pwm),
		.pc_pwm(pc_pwm),
		.count_up(dir == TCC_UP),
		.out_mode(compare_output_mode_a),
		.cmp_active(cmp_a),
		.cmp_buffer(compare_value_a),
		.pin(compare_pin_a)
	);

	tcc_chan u_chan_b (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.cpu_wr(compare_wr_b && enabled),
		.cpu_data(compare_wr_data),
		.reload(reload),
		.match(match_b),
		.bottom_evt(bottom_evt),
		.force_strobe(force_compare_strobe_b && enabled),
		.fast_pwm(fast_pwm),
		.pc_pwm(pc_pwm),
		.count_up(dir == TCC_UP),
		.out_mode(compare_output_mode_b),
		.cmp_active(cmp_b),
		.cmp_buffer(compare_value_b),
		.pin(compare_pin_b)
	);

	////////////////////////////////////////////////////////////////////
	// Flags and requests

	logic [2:0] flag_set;
	logic [2:0] flag_clr;

	// Forced strobes never reach these flags
	assign flag_set = {match_b, match_a, ovf_evt};
	assign flag_clr = (flag_wr ? flag_wr_data : 3'b000) | irq_ack;

	// A set arriving with a clear is kept
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			timer_flag_reg <= `TCC_FLAG_RST;
		end else begin
			timer_flag_reg <= flag_set | (timer_flag_reg & ~flag_clr);
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_req <= 3'b000;
		end else begin
			irq_req <= timer_flag_reg & timer_mask_reg & ~flag_clr;
		end
	end
endmodule

// file: sim/tcc_assertions.sv
// Port-level concurrent checks for the timer compare core
`timescale 1ns/1ps
module tcc_chk
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Configuration
	input wire logic power_reduce_timer,
	input wire logic async_select,
	input wire logic [2:0] clock_select_field,
	input wire logic waveform_mode_bit0,
	input wire logic waveform_mode_bit1,
	input wire logic waveform_mode_bit2,
	// Writes and clears
	input wire logic count_wr,
	input wire tcc_byte_t count_wr_data,
	input wire logic flag_wr,
	input wire logic [2:0] flag_wr_data,
	input wire logic [2:0] irq_ack,
	input wire logic [2:0] timer_mask_reg,
	// Status
	input wire tcc_byte_t count_value,
	input wire logic [2:0] timer_flag_reg,
	input wire logic [2:0] irq_req,
	input wire logic at_bottom,
	input wire logic at_max
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [2:0] clr_req;
	logic [2:0] mode;
	assign clr_req = ({3{flag_wr}} & flag_wr_data) | irq_ack;
	assign mode = {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0};
	////////////////////////////////////////////////////////////////////////
	// Two quiet cycles before each step or stop check; the tick enable is combinational
	sequence s_run;
		!power_reduce_timer && !async_select && !count_wr &&
		clock_select_field == 3'h1 && mode == 3'h0;
	endsequence
	sequence s_stop;
		clock_select_field == 3'h0 && !count_wr;
	endsequence
	property p_step;
		s_run ##1 s_run |=> count_value == $past(count_value) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("count step wrong");
	property p_stop;
		s_stop ##1 s_stop |=> $stable(count_value);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped count moved");
	property p_power;
		power_reduce_timer [*2] |=> $stable(count_value);
	endproperty
	a_power: assert property (p_power) else $error("count moved while off");
	property p_write;
		count_wr && !power_reduce_timer |=> count_value == $past(count_wr_data);
	endproperty
	a_write: assert property (p_write) else $error("count write lost");
	property p_block;
		count_wr && !power_reduce_timer |=>
			(timer_flag_reg & ~$past(timer_flag_reg)) == 3'h0;
	endproperty
	a_block: assert property (p_block) else $error("flag set after write");
	property p_irq;
		(irq_req & ~$past(timer_flag_reg & timer_mask_reg)) == 3'h0;
	endproperty
	a_irq: assert property (p_irq) else $error("request not gated");
	property p_fall;
		(~timer_flag_reg & $past(timer_flag_reg) & ~$past(clr_req)) == 3'h0;
	endproperty
	a_fall: assert property (p_fall) else $error("flag dropped alone");
	property p_bottom;
		at_bottom == ($past(count_value) == 8'h00);
	endproperty
	a_bottom: assert property (p_bottom) else $error("bottom wrong");
	property p_max;
		at_max == ($past(count_value) == 8'hFF);
	endproperty
	a_max: assert property (p_max) else $error("max wrong");
endmodule
bind tcc_top tcc_chk u_chk (.clk_sys, .sys_rst, .power_reduce_timer,
	.async_select, .clock_select_field, .waveform_mode_bit0,
	.waveform_mode_bit1, .waveform_mode_bit2, .count_wr, .count_wr_data,
	.flag_wr, .flag_wr_data, .irq_ack, .timer_mask_reg, .count_value,
	.timer_flag_reg, .irq_req, .at_bottom, .at_max);

// file: sim/tcc_tb_top.sv
// Self-checking bench for the timer compare core
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tcc_tb_top;
	import tcc_pkg::*;
	logic clk_sys = 1'b0, sys_rst = 1'b1, pr = 1'b0, asel = 1'b0;
	logic cw = 1'b0, kwa = 1'b0, kwb = 1'b0, fw = 1'b0, osc = 1'b0;
	logic fsa = 1'b0, fsb = 1'b0;
	logic [2:0] cs = '0, wm = '0, fwd = '0, ack = '0, msk = '0;
	logic [1:0] coma = '0, comb = '0;
	tcc_byte_t cwd = '0, kd = '0, c, p;
	logic osc_o, bot, mx, pa, pb;
	tcc_byte_t cnt, cva, cvb;
	logic [2:0] flg, irq;
	int fails = 0, total_checks = 0;
	tcc_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.power_reduce_timer(pr), .async_select(asel), .clock_select_field(cs),
		.waveform_mode_bit0(wm[0]), .waveform_mode_bit1(wm[1]),
		.waveform_mode_bit2(wm[2]), .compare_output_mode_a(coma),
		.compare_output_mode_b(comb), .count_wr(cw), .count_wr_data(cwd),
		.compare_wr_a(kwa), .compare_wr_b(kwb), .compare_wr_data(kd),
		.force_compare_strobe_a(fsa), .force_compare_strobe_b(fsb),
		.flag_wr(fw), .flag_wr_data(fwd), .irq_ack(ack), .timer_mask_reg(msk),
		.osc_pin_in(osc), .osc_pin_out(osc_o), .count_value(cnt),
		.compare_value_a(cva), .compare_value_b(cvb), .timer_flag_reg(flg),
		.irq_req(irq), .at_bottom(bot), .at_max(mx), .compare_pin_a(pa),
		.compare_pin_b(pb));
	always #4 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////
	function automatic tcc_byte_t ctc_next(tcc_byte_t v, tcc_byte_t top);
		return (v == top) ? 8'h00 : v + 8'h01;
	endfunction
	task automatic cyc(int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wcnt(tcc_byte_t d);
		cw = 1'b1;
		cwd = d;
		cyc(1);
		cw = 1'b0;
	endtask
	task automatic wcmp(tcc_byte_t d);
		kwa = 1'b1;
		kwb = 1'b1;
		kd = d;
		cyc(1);
		kwa = 1'b0;
		kwb = 1'b0;
	endtask
	// Bounded so a stuck counter ends in a mismatch, not a hang
	task automatic waitc(tcc_byte_t v);
		for (int k = 0; k < 600 && cnt !== v; k++) cyc(1);
	endtask
	task automatic results;
		if (fails == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#(8 * 20000);
		fails++;
		results;
	end
	initial begin
		void'($urandom(24));
		cyc(10);
		sys_rst = 1'b0;
		cyc(1);
		`CHK({cnt, flg, bot}, 12'h001)
		pr = 1'b1;
		wcnt(8'h5A);
		cyc(1);
		`CHK(cnt, 8'h00)
		pr = 1'b0;
		c = tcc_byte_t'($urandom_range(200, 20));
		wcnt(c);
		cyc(5);
		`CHK(cnt, c)
		wcmp(c);
		`CHK({cva, cvb}, {c, c})
		wcnt(c - 8'h08);
		cs = 3'h1;
		waitc(c);
		`CHK(flg, 3'h0)
		cyc(1);
		`CHK({cnt, flg}, {c + 8'h01, 3'h6})
		cs = 3'h0;
		fw = 1'b1;
		cyc(1);
		`CHK(flg, 3'h6)
		fwd = 3'h4;
		cyc(1);
		fw = 1'b0;
		`CHK(flg, 3'h2)
		msk = 3'h2;
		cyc(2);
		`CHK(irq, 3'h2)
		ack = 3'h2;
		cyc(1);
		ack = 3'h0;
		cyc(1);
		`CHK({flg, irq}, 6'h00)
		wcnt(c);
		cs = 3'h1;
		waitc(c + 8'h02);
		`CHK(flg, 3'h0)
		cs = 3'h0;
		wcnt(8'hFD);
		cs = 3'h1;
		waitc(8'h00);
		`CHK(mx, 1'b1)
		waitc(8'h01);
		`CHK({flg[0], bot}, 2'b11)
		cs = 3'h0;
		wcnt(8'h00);
		wm = 3'h2;
		cs = 3'h1;
		cyc(2);
		repeat (3 * c) begin
			p = cnt;
			cyc(1);
			`CHK(cnt, ctc_next(p, c))
		end
		cs = 3'h0;
		wm = 3'h0;
		for (int m = 3; m >= 2; m--) begin
			coma = m[1:0];
			comb = m[1:0];
			fsa = 1'b1;
			fsb = 1'b1;
			cyc(1);
			fsa = 1'b0;
			fsb = 1'b0;
			cyc(3);
			`CHK({pa, pb}, {2{m[0]}})
		end
		// Fast PWM: buffered compare reloads only at bottom
		wm = 3'h3;
		wcmp(8'hE0);
		`CHK({cva, cvb}, 16'hE0E0)
		fw = 1'b1;
		fwd = 3'h7;
		wcnt(8'hDA);
		fw = 1'b0;
		cs = 3'h1;
		waitc(8'h01);
		`CHK({flg[2:1], pa, pb}, 4'b0011)
		waitc(8'hD0);
		`CHK({pa, pb}, 2'b11)
		waitc(8'hE2);
		`CHK({flg[2:1], pa, pb}, 4'b1100)
		// Phase correct with top from compare A turns at E0
		cs = 3'h0;
		wm = 3'h5;
		wcnt(8'hDF);
		cs = 3'h1;
		cyc(3);
		`CHK(cnt, 8'hDE)
		cs = 3'h0;
		wm = 3'h0;
		wcnt(8'h10);
		asel = 1'b1;
		cyc(8);
		cs = 3'h1;
		repeat (4) begin
			osc = 1'b1;
			cyc(7);
			`CHK(osc_o, 1'b0)
			osc = 1'b0;
			cyc(7);
		end
		cyc(8);
		`CHK(cnt, 8'h14)
		results;
	end
endmodule
